// ---- logic/dtm_pkg.sv ----
// package for the debug and test mode fault monitor
// assumes a single 50 MHz system clock and an apb register bus
package dtm_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int HOLD_US = 250;
   localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
   localparam int DELTA_MAX_US = 10000;
   localparam int CNT_W = 20;

   // ----------------------------------------------------------------
   // fault collection channels
   // ----------------------------------------------------------------
   localparam int CH_TEST1 = 46;
   localparam int CH_TEST4 = 49;
   localparam int CH_SAFE = 52;
   localparam int CH_COMP = 53;
   localparam int CH_DEBUG = 54;
   localparam int CH_TMODE = 55;
   localparam int NCH = 64;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_CLEAR = 12'h008;
   localparam logic [11:0] OFF_IRQ_EN = 12'h00c;
   localparam logic [11:0] OFF_MODE_CFG = 12'h010;
   localparam logic [11:0] OFF_MODE_REQ = 12'h014;
   localparam logic [11:0] OFF_MODE_STAT = 12'h018;
   localparam logic [11:0] OFF_DELTA = 12'h01c;
   localparam logic [11:0] OFF_CH_EN = 12'h020;
   localparam logic [11:0] OFF_CH_EN_HI = 12'h024;
   localparam logic [11:0] OFF_TEST_SET = 12'h028;

   // ctrl bit positions
   localparam int CTRL_NMI_REL = 0;
   localparam int CTRL_SLOT_EXC = 1;
   localparam int CTRL_WDOG_RUN = 2;

   // status / event bit positions
   localparam int EV_DEBUG = 0;
   localparam int EV_TMODE = 1;
   localparam int EV_TEST = 2;
   localparam int EV_COMP = 3;
   localparam int EV_SAFE = 4;
   localparam int EV_SLOT = 5;
   localparam int NEV = 6;

   // the seven settings, shared by all four test-circuit inputs
   localparam int NSET = 7;
   localparam logic [6:0] TEST_SET_RST = 7'h00;
   localparam logic [31:0] CH_EN_RST = 32'h00000000;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [3:0] MODE_SAFE = 4'h2;

   // unused slot decode: register window is 11 words, this is the first offset past it
   localparam logic [11:0] LAST_OFF = 12'h02c;
endpackage

// ---- logic/dtm_sync.sv ----
// two-flop synchroniser for boot-time pins and fault levels
// assumes the input may change at any time relative to ref_clk
`timescale 1ns/1ps
module dtm_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // dtm_sync

// ---- logic/dtm_hold.sv ----
// failure indication hold timer
// assumes fault_evt is a one-cycle pulse in the ref_clk domain
`timescale 1ns/1ps
module dtm_hold
   import dtm_pkg::*;
#(
   parameter int HOLD = HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic fault_evt,
   input wire logic [13:0] delta_us,
   output logic fail_ind
);
   logic [CNT_W+6:0] cnt;

   // -----------------------------------------------------------------
   // hold counter: restarts on every new fault
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt <= '0;
      end else if (fault_evt) begin
         cnt <= (CNT_W+7)'(HOLD + int'(delta_us) * CLK_MHZ); // [R15]
      end else if (cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign fail_ind = (cnt != '0);

   a_hold_restart: assert property (@(posedge ref_clk) disable iff (rst)
      fault_evt |=> fail_ind [*8]) // [R15]
      else $error("failure indication dropped early");
endmodule // dtm_hold

// ---- logic/dtm_monitor.sv ----
// debug and test mode fault monitor with apb register file
// assumes apb master on ref_clk, synchronous active-high rst
//
// Notes on behaviour
// R1: compliance pin low holds the test port controller in reset.
// R2: compliance pin high enables test port controller; debug may follow a request.
// R3: compliance pin high during boot raises a fault to fault collection.
// R4: outside system keeps compliance pin low during boot.
// R5: outside system never asserts test-mode pin at boot; leave floating.
// R6: any entry to factory test mode raises a fault.
// R7: test-circuit fault inputs one to four drive channels 46 to 49.
// R8: each test-circuit input passes only when all seven settings enable it.
// R9: clock compensation disable reports on channel 52+1, namely 53.
// R10: safe mode entry reports on channel 52.
// R11: functional reset masks fault nmi until boot assist code releases it.
// R12: mode configuration applies only on a transition request; status shows current.
// R13: when enabled, access to an unimplemented slot raises an exception.
// R14: software watchdog may be set to keep running in debug mode.
// R15: failure indication holds 250 us plus delta, restarting on new faults.
// R16: fault outputs are synchronised levels held while the condition lasts.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module dtm_monitor
   import dtm_pkg::*;
#(
   parameter int HOLD = HOLD_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic func_rst,
   input wire logic booting,
   input wire logic debug_compliance_pin,
   input wire logic test_mode_pin,
   input wire logic debug_req,
   input wire logic [3:0] test_circuit_fault_input,
   input wire logic comp_disable,
   input wire logic fault_nmi_in,
   input wire logic slot_access,
   input wire logic slot_implemented,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic test_port_controller_rst,
   output logic debug_mode,
   output logic watchdog_freeze,
   output logic [NCH-1:0] fault_collection_unit,
   output logic fault_nmi_out,
   output logic slot_exception,
   output logic fail_ind,
   output logic [3:0] current_mode,
   output logic irq
);
   logic comp_s;
   logic tmode_s;
   logic dbgreq_s;
   logic [3:0] tcf_s;
   logic cdis_s;
   logic [2:0] ctrl;
   logic [NEV-1:0] status;
   logic [NEV-1:0] irq_en;
   logic [3:0] mode_cfg;
   logic [13:0] delta;
   logic [6:0] test_set;
   logic [3:0] test_en;
   logic [63:0] ch_en;
   logic boot_debug;
   logic nmi_mask;
   logic [NEV-1:0] ev;
   logic [NEV-1:0] lvl_d;
   logic [NEV-1:0] lvl;
   logic wr;
   logic rd;
   logic [31:0] next_prdata;
   logic mapped;
   logic slot_bad;

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   dtm_sync #(.W(8)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .din({debug_compliance_pin, test_mode_pin, debug_req, test_circuit_fault_input,
            comp_disable}),
      .dout({comp_s, tmode_s, dbgreq_s, tcf_s, cdis_s})
   );

   // -----------------------------------------------------------------
   // test port controller and debug mode
   // -----------------------------------------------------------------
   assign test_port_controller_rst = ~comp_s; // [R1]

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         debug_mode <= 1'b0;
      end else if (!comp_s) begin
         debug_mode <= 1'b0; // [R1]
      end else if (dbgreq_s) begin
         debug_mode <= 1'b1; // [R2]
      end
   end

   // freeze only if software did not ask the watchdog to keep running
   assign watchdog_freeze = debug_mode & ~ctrl[CTRL_WDOG_RUN]; // [R14]

   // boot-time compliance latch: stays until reset, cannot be cleared by software
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         boot_debug <= 1'b0;
      end else if (booting && comp_s) begin
         boot_debug <= 1'b1; // [R3]
      end
   end

   // -----------------------------------------------------------------
   // test-circuit inputs gated by all seven settings
   // -----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         test_en[i] = tcf_s[i] & (&test_set) & ch_en[CH_TEST1 + i]; // [R8]
      end
   end

   // -----------------------------------------------------------------
   // mode entry: config applies only on a transition request
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         current_mode <= MODE_RST;
      end else if (wr && paddr == OFF_MODE_REQ && pwdata[0]) begin
         current_mode <= mode_cfg; // [R12]
      end
   end

   // -----------------------------------------------------------------
   // fault outputs toward fault collection
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fault_collection_unit <= '0;
      end else begin
         fault_collection_unit <= '0;
         fault_collection_unit[CH_TEST4:CH_TEST1] <= test_en; // [R7] [R16]
         fault_collection_unit[CH_SAFE] <= (current_mode == MODE_SAFE) & ch_en[CH_SAFE]; // [R10]
         fault_collection_unit[CH_COMP] <= cdis_s & ch_en[CH_COMP]; // [R9]
         fault_collection_unit[CH_DEBUG] <= boot_debug; // [R3] [R16]
         fault_collection_unit[CH_TMODE] <= tmode_s; // [R6] [R16]
      end
   end

   // -----------------------------------------------------------------
   // nmi mask across functional reset
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst || func_rst) begin
         nmi_mask <= 1'b1; // [R11]
      end else if (wr && paddr == OFF_CTRL && pwdata[CTRL_NMI_REL]) begin
         nmi_mask <= 1'b0; // [R11]
      end
   end

   assign fault_nmi_out = fault_nmi_in & ~nmi_mask; // [R11]

   // -----------------------------------------------------------------
   // unimplemented slot exception
   // -----------------------------------------------------------------
   assign slot_bad = slot_access & ~slot_implemented & ctrl[CTRL_SLOT_EXC];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         slot_exception <= 1'b0;
      end else begin
         slot_exception <= slot_bad; // [R13]
      end
   end

   // -----------------------------------------------------------------
   // events, sticky status and interrupt
   // -----------------------------------------------------------------
   assign lvl = {slot_exception, fault_collection_unit[CH_SAFE], fault_collection_unit[CH_COMP],
                 |fault_collection_unit[CH_TEST4:CH_TEST1], fault_collection_unit[CH_TMODE],
                 fault_collection_unit[CH_DEBUG]};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lvl_d <= '0;
      end else begin
         lvl_d <= lvl;
      end
   end

   assign ev = lvl & ~lvl_d;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status <= '0;
      end else if (wr && paddr == OFF_CLEAR) begin
         // a new event wins over a clear in the same cycle
         status <= (status & ~pwdata[NEV-1:0]) | ev;
      end else begin
         status <= status | ev;
      end
   end

   assign irq = |(status & irq_en);

   dtm_hold #(.HOLD(HOLD)) u_hold (
      .ref_clk(ref_clk),
      .rst(rst),
      .fault_evt(|ev),
      .delta_us(delta),
      .fail_ind(fail_ind)
   );

   // -----------------------------------------------------------------
   // apb slave: zero wait states
   // -----------------------------------------------------------------
   assign pready = 1'b1;
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_TEST_SET);
   assign pslverr = psel & penable & ~mapped;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl <= '0;
         irq_en <= '0;
         mode_cfg <= MODE_RST;
         delta <= '0;
         ch_en <= {CH_EN_RST, CH_EN_RST};
         test_set <= TEST_SET_RST;
      end else if (wr) begin
         case (paddr)
            OFF_CTRL: ctrl <= {pwdata[CTRL_WDOG_RUN], pwdata[CTRL_SLOT_EXC], 1'b0};
            OFF_IRQ_EN: irq_en <= pwdata[NEV-1:0];
            OFF_MODE_CFG: mode_cfg <= pwdata[3:0]; // [R12]
            OFF_DELTA: delta <= (pwdata[13:0] > 14'(DELTA_MAX_US)) ?
                                14'(DELTA_MAX_US) : pwdata[13:0];
            OFF_CH_EN: ch_en[31:0] <= pwdata;
            OFF_CH_EN_HI: ch_en[63:32] <= pwdata;
            OFF_TEST_SET: test_set <= pwdata[NSET-1:0]; // [R8]
            default: ;
         endcase
      end
   end

   always_comb begin
      next_prdata = 32'h00000000;
      case (paddr)
         OFF_CTRL: next_prdata = {29'h0, ctrl[2:1], ~nmi_mask};
         OFF_STATUS: next_prdata = {26'h0, status};
         OFF_IRQ_EN: next_prdata = {26'h0, irq_en};
         OFF_MODE_CFG: next_prdata = {28'h0, mode_cfg};
         OFF_MODE_STAT: next_prdata = {28'h0, current_mode}; // [R12]
         OFF_DELTA: next_prdata = {18'h0, delta};
         OFF_CH_EN: next_prdata = ch_en[31:0];
         OFF_CH_EN_HI: next_prdata = ch_en[63:32];
         OFF_TEST_SET: next_prdata = {25'h0, test_set};
         default: next_prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata <= '0;
      end else if (rd) begin
         prdata <= next_prdata;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence s_comp_low;
      !comp_s ##1 !comp_s;
   endsequence

   a_tap_reset: assert property (@(posedge ref_clk) disable iff (rst)
      !comp_s |-> test_port_controller_rst ##1 !debug_mode) // [R1]
      else $error("test port controller not held in reset");
   a_debug_entry: assert property (@(posedge ref_clk) disable iff (rst)
      comp_s && dbgreq_s |=> debug_mode) // [R2]
      else $error("debug mode not entered on request");
   a_debug_exit: assert property (@(posedge ref_clk) disable iff (rst)
      s_comp_low |-> !debug_mode) // [R1]
      else $error("debug mode while compliance low");
   a_boot_fault: assert property (@(posedge ref_clk) disable iff (rst)
      booting && comp_s |-> ##2 fault_collection_unit[CH_DEBUG]) // [R3]
      else $error("boot compliance fault missing");
   a_tmode_fault: assert property (@(posedge ref_clk) disable iff (rst)
      tmode_s |=> fault_collection_unit[CH_TMODE]) // [R6]
      else $error("test mode fault missing");
   a_test_map: assert property (@(posedge ref_clk) disable iff (rst)
      test_en[0] |=> fault_collection_unit[CH_TEST1]) // [R7]
      else $error("test input one not on channel 46");
   a_test_gate: assert property (@(posedge ref_clk) disable iff (rst)
      !(&test_set) |=> fault_collection_unit[CH_TEST4:CH_TEST1] == 4'h0) // [R8]
      else $error("test input passed without all settings");
   a_comp_fault: assert property (@(posedge ref_clk) disable iff (rst)
      cdis_s && ch_en[CH_COMP] |=> fault_collection_unit[CH_COMP]) // [R9]
      else $error("compensation fault missing");
   a_nmi_mask: assert property (@(posedge ref_clk) disable iff (rst)
      func_rst |=> !fault_nmi_out) // [R11]
      else $error("nmi passed after functional reset");
   a_mode_hold: assert property (@(posedge ref_clk) disable iff (rst)
      !(wr && paddr == OFF_MODE_REQ) |=> $stable(current_mode)) // [R12]
      else $error("mode changed without request");
   a_slot_exc: assert property (@(posedge ref_clk) disable iff (rst)
      slot_bad |=> slot_exception) // [R13]
      else $error("slot exception missing");
endmodule // dtm_monitor

// ---- bench/dtm_far_model.sv ----
// far-side model: boot-pin driver and fault collection unit
// assumes ref_clk domain; the bench commands the pins by plain levels
`timescale 1ns/1ps
module dtm_far_model
   import dtm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [NCH-1:0] faults,
   input wire logic boot_go,
   input wire logic dbg_on,
   input wire logic tst_on,
   input wire logic brk,
   output logic booting,
   output logic debug_compliance_pin,
   output logic test_mode_pin,
   output logic fault_nmi_in
);
   // ------------------------------------------------
   // boot pins
   // ------------------------------------------------
   // pins stay low during boot unless a scenario breaks this on purpose
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         booting <= 1'b0;
         debug_compliance_pin <= 1'b0;
         test_mode_pin <= 1'b0;
      end else begin
         booting <= boot_go;
         debug_compliance_pin <= dbg_on & (~boot_go | brk);
         test_mode_pin <= tst_on & (~boot_go | brk);
      end
   end
   // ------------------------------------------------
   // fault collection: nmi while any channel reports
   // ------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fault_nmi_in <= 1'b0;
      end else begin
         fault_nmi_in <= |faults;
      end
   end
endmodule // dtm_far_model

// ---- bench/tb_dtm_monitor.sv ----
// self-checking bench for the debug and test mode fault monitor
// assumes a short hold count; all inputs move by nba at rising edges
`timescale 1ns/1ps
module tb_dtm_monitor
   import dtm_pkg::*;
;
   // ------------------------------------------------
   // signals
   // ------------------------------------------------
   logic ref_clk, rst, func_rst, debug_req, comp_disable, slot_access, slot_implemented;
   logic psel, penable, pwrite, pready, pslverr, booting, dbg_pin, tst_pin, nmi_in;
   logic tap_rst, debug_mode, watchdog_freeze, fault_nmi_out, slot_exception, fail_ind, irq;
   logic boot_go, dbg_on, tst_on, brk;
   logic [3:0] tcf, current_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [NCH-1:0] fcu;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;

   dtm_monitor #(.HOLD(20)) dtm_monitor_i (.ref_clk(ref_clk), .rst(rst), .func_rst(func_rst),
      .booting(booting), .debug_compliance_pin(dbg_pin), .test_mode_pin(tst_pin),
      .debug_req(debug_req), .test_circuit_fault_input(tcf), .comp_disable(comp_disable),
      .fault_nmi_in(nmi_in), .slot_access(slot_access), .slot_implemented(slot_implemented),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .test_port_controller_rst(tap_rst),
      .debug_mode(debug_mode), .watchdog_freeze(watchdog_freeze), .fault_collection_unit(fcu),
      .fault_nmi_out(fault_nmi_out), .slot_exception(slot_exception), .fail_ind(fail_ind),
      .current_mode(current_mode), .irq(irq));

   dtm_far_model dtm_far_model_i (.ref_clk(ref_clk), .rst(rst), .faults(fcu), .boot_go(boot_go),
      .dbg_on(dbg_on), .tst_on(tst_on), .brk(brk), .booting(booting),
      .debug_compliance_pin(dbg_pin), .test_mode_pin(tst_pin), .fault_nmi_in(nmi_in));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one apb transfer; entered just after a rising edge, leaves one idle edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      logic er;
      apb(1'b0, a, 32'h0, r, er);
      chk(nm, e, r);
      chk("read err", 32'h0, {31'h0, er});
   endtask

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_reset;
      logic [31:0] r;
      logic er;
      chk("tap rst", 32'h1, {31'h0, tap_rst});
      rchk("status", OFF_STATUS, 32'h0);
      rchk("mode stat", OFF_MODE_STAT, {28'h0, MODE_RST});
      apb(1'b0, LAST_OFF, 32'h0, r, er);
      chk("unmapped err", 32'h1, {31'h0, er});
      apb(1'b1, 12'h006, 32'h0, r, er);
      chk("misaligned err", 32'h1, {31'h0, er});
      $display("test reset done");
   endtask

   task automatic t_debug;
      dbg_on <= 1'b1;
      cyc(5);
      chk("tap rst", 32'h0, {31'h0, tap_rst});
      chk("boot debug ch", 32'h0, {31'h0, fcu[CH_DEBUG]});
      debug_req <= 1'b1;
      cyc(5);
      chk("debug mode", 32'h1, {31'h0, debug_mode});
      chk("wdog freeze", 32'h1, {31'h0, watchdog_freeze});
      wr(OFF_CTRL, 32'h1 << CTRL_WDOG_RUN);
      cyc(1);
      chk("wdog freeze", 32'h0, {31'h0, watchdog_freeze});
      dbg_on <= 1'b0;
      debug_req <= 1'b0;
      cyc(5);
      chk("tap rst", 32'h1, {31'h0, tap_rst});
      $display("test debug done");
   endtask

   // test mode entry, hold restart by a second fault, irq set/clear/mask
   task automatic t_tmode;
      wr(OFF_IRQ_EN, 32'h1 << EV_TMODE);
      tst_on <= 1'b1;
      cyc(6);
      chk("test mode ch", 32'h1, {31'h0, fcu[CH_TMODE]});
      chk("fail ind", 32'h1, {31'h0, fail_ind});
      chk("irq", 32'h1, {31'h0, irq});
      cyc(8);
      comp_disable <= 1'b1;
      cyc(16);
      chk("fail ind restart", 32'h1, {31'h0, fail_ind});
      chk("comp ch", 32'h1, {31'h0, fcu[CH_COMP]});
      cyc(20);
      chk("fail ind end", 32'h0, {31'h0, fail_ind});
      tst_on <= 1'b0;
      comp_disable <= 1'b0;
      cyc(5);
      chk("levels gone", 32'h0, {30'h0, fcu[CH_TMODE], fcu[CH_COMP]});
      wr(OFF_CLEAR, 32'h3f);
      rchk("status clr", OFF_STATUS, 32'h0);
      chk("irq clr", 32'h0, {31'h0, irq});
      wr(OFF_IRQ_EN, 32'h0);
      tst_on <= 1'b1;
      cyc(5);
      rchk("status set", OFF_STATUS, 32'h1 << EV_TMODE);
      chk("irq masked", 32'h0, {31'h0, irq});
      tst_on <= 1'b0;
      cyc(5);
      wr(OFF_CLEAR, 32'h3f);
      $display("test test-mode done");
   endtask

   task automatic t_inputs;
      wr(OFF_TEST_SET, 32'h7f);
      for (int i = 0; i < 4; i++) begin
         tcf <= 4'h1 << i;
         cyc(5);
         chk("test ch", 32'h1 << i, {28'h0, fcu[CH_TEST4:CH_TEST1]});
         tcf <= 4'h0;
         cyc(5);
      end
      for (int j = 0; j < NSET; j++) begin
         wr(OFF_TEST_SET, 32'h7f & ~(32'h1 << j));
         tcf <= 4'hf;
         cyc(5);
         chk("test gated", 32'h0, {28'h0, fcu[CH_TEST4:CH_TEST1]});
         tcf <= 4'h0;
         cyc(2);
      end
      $display("test inputs done");
   endtask

   task automatic t_safe;
      wr(OFF_MODE_CFG, {28'h0, MODE_SAFE});
      cyc(3);
      rchk("mode before req", OFF_MODE_STAT, {28'h0, MODE_RST});
      chk("safe ch", 32'h0, {31'h0, fcu[CH_SAFE]});
      wr(OFF_DELTA, 32'h3fff);
      rchk("delta clamp", OFF_DELTA, 32'(DELTA_MAX_US));
      wr(OFF_DELTA, 32'h1);
      wr(OFF_MODE_REQ, 32'h1);
      cyc(5);
      chk("mode after req", {28'h0, MODE_SAFE}, {28'h0, current_mode});
      chk("safe ch", 32'h1, {31'h0, fcu[CH_SAFE]});
      cyc(40);
      chk("fail ind delta", 32'h1, {31'h0, fail_ind});
      cyc(40);
      chk("fail ind delta end", 32'h0, {31'h0, fail_ind});
      $display("test safe done");
   endtask

   task automatic t_boot_nmi;
      boot_go <= 1'b1;
      brk <= 1'b1;
      dbg_on <= 1'b1;
      cyc(6);
      chk("boot debug ch", 32'h1, {31'h0, fcu[CH_DEBUG]});
      boot_go <= 1'b0;
      brk <= 1'b0;
      dbg_on <= 1'b0;
      cyc(3);
      chk("nmi masked", 32'h0, {31'h0, fault_nmi_out});
      wr(OFF_CTRL, 32'h1 << CTRL_NMI_REL);
      cyc(1);
      chk("nmi released", 32'h1, {31'h0, fault_nmi_out});
      func_rst <= 1'b1;
      cyc(1);
      func_rst <= 1'b0;
      cyc(2);
      chk("nmi remasked", 32'h0, {31'h0, fault_nmi_out});
      $display("test boot nmi done");
   endtask

   task automatic t_slot;
      slot_implemented <= 1'b0;
      slot_access <= 1'b1;
      cyc(3);
      chk("slot off", 32'h0, {31'h0, slot_exception});
      wr(OFF_CTRL, 32'h1 << CTRL_SLOT_EXC);
      cyc(1);
      chk("slot exc", 32'h1, {31'h0, slot_exception});
      slot_implemented <= 1'b1;
      cyc(3);
      chk("slot present", 32'h0, {31'h0, slot_exception});
      slot_access <= 1'b0;
      $display("test slot done");
   endtask

   // ------------------------------------------------
   // main sequence and timeout
   // ------------------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         give_verdict();
      end
   end

   initial begin
      {rst, func_rst, debug_req, comp_disable, slot_access, psel, penable, pwrite} = 8'h80;
      {boot_go, dbg_on, tst_on, brk, slot_implemented} = 5'h01;
      tcf = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      cyc(5);
      rst <= 1'b0;
      cyc(3);
      t_reset();
      wr(OFF_CH_EN, 32'hffffffff);
      wr(OFF_CH_EN_HI, 32'hffffffff);
      t_debug();
      t_tmode();
      t_inputs();
      t_safe();
      t_boot_nmi();
      t_slot();
      give_verdict();
   end
endmodule // tb_dtm_monitor
